/* level_sense_map.svh */
// named offsets, fields, thresholds and timing figures of the level sensor
// assumes inclusion by bare name from every file that needs a figure
`ifndef LEVEL_SENSE_MAP_SVH
`define LEVEL_SENSE_MAP_SVH
`define CLK_HZ 10000000
`define COUNT_BITS 14
`define LOW_LEVEL_THRESHOLD 250
`define HIGH_LEVEL_THRESHOLD 150
`define ACQ_PERIOD_MS 100
`define SLOSH_WINDOW_S 15
`define HEALTH_PULSE_US 50
`define SWITCH_NS 400
`define DUMP_PHASES 4
`define REG_CONTROL 12'h000
`define REG_COUNT 12'h004
`define REG_STATUS 12'h008
`define CTRL_ACQ_EN 0
`define CTRL_RESET 32'h00000001
`define ST_RAW_LOW 0
`define ST_RAW_HIGH 1
`define ST_OUT_LOW 2
`define ST_OUT_HIGH 3
`define ST_OPT_ACTIVE_HIGH 4
`define ST_OPT_FILTER 5
`define ST_BUSY 6
`define ST_SATURATED 7
`endif

/* level_pkg.sv */
// types shared by the level sensor back end
// assumes nothing beyond the map header
package level_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_DUMP = 5'h02,
    ST_CHARGE = 5'h04,
    ST_TRANSFER = 5'h08,
    ST_EVAL = 5'h10
  } acq_state_type;
  typedef logic [1:0] detect_type;
  localparam int CH_LOW = 0;
  localparam int CH_HIGH = 1;
endpackage

/* slosh_if.sv */
// carrier between the acquisition core and the slosh filter
// assumes both ends share one clock
`timescale 1ns/1ns
interface slosh_if;
  logic sampleStrobe;
  level_pkg::detect_type rawDetect;
  logic filterEnable;
  level_pkg::detect_type filtered;
  modport source (output sampleStrobe, output rawDetect, output filterEnable,
    input filtered);
  modport filter (input sampleStrobe, input rawDetect, input filterEnable,
    output filtered);
endinterface

/* slosh_filter.sv */
// rolling majority filter over the last DEPTH burst results, per channel
// assumes one sample strobe per finished burst
`timescale 1ns/1ns
module slosh_filter #(
  parameter int DEPTH = 150
) (
  input wire logic clk,
  input wire logic sys_rst,
  slosh_if.filter link
);
  import level_pkg::*;
  localparam int OW = $clog2(DEPTH + 1);
  generate
    if (DEPTH < 3)
    begin : g_bad
      $error("slosh filter depth too small");
    end
  endgenerate
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_ch
      logic [DEPTH-1:0] history;
      logic [OW-1:0] ones;
      logic [OW-1:0] next_ones;
      logic [OW:0] twice;
      always_comb
      begin
        next_ones = ones + OW'(link.rawDetect[ch]) - OW'(history[DEPTH-1]);
        twice = {next_ones, 1'b0};
      end
      always_ff @(posedge clk)
      begin
        if (sys_rst)
        begin
          history <= '0;
          ones <= '0;
        end
        else if (link.sampleStrobe)
        begin
          history <= {history[DEPTH-2:0], link.rawDetect[ch]};
          ones <= next_ones;
        end
      end
      // majority moves output
      // ties hold the present state, so an even depth cannot chatter
      always_ff @(posedge clk)
      begin
        if (sys_rst)
          link.filtered[ch] <= 1'b0;
        else if (link.sampleStrobe)
        begin
          if (!link.filterEnable)
            link.filtered[ch] <= link.rawDetect[ch];
          else if (twice > (OW + 1)'(DEPTH))
            link.filtered[ch] <= 1'b1;
          else if (twice < (OW + 1)'(DEPTH))
            link.filtered[ch] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule // slosh_filter

/* level_threshold_output_logic.sv */
// digital back end of a two-tier charge-transfer level sensor
// assumes an external comparator flags when Cs reaches the reference,
// external switches driven by the switch outputs, and an APB master
// Overview of operation
// - each measurement is a short burst of charge-transfer cycles, repeated at low duty.
// - the count has 14 bits and the counter and comparators are that wide.
// - the burst stops once Cs is charged, so faster charge buildup gives a smaller count.
// - the count is compared with 250 for the low tier and 150 for the high tier.
// - a count below a threshold means detection for that threshold.
// - the low tier drives the low-level output and the high tier the high-level output.
// - with the slosh filter on, detections are averaged over a rolling 15 s window.
// - one option pin picks output polarity, the other switches the slosh filter in.
// - polarity applies to both outputs together.
// - no timeout, drift compensation or adaptive threshold; detection lasts with the count.
// - a periodic health indication appears on both outputs.
`timescale 1ns/1ns
`include "level_sense_map.svh"
module level_threshold_output_logic #(
  parameter int COUNT_WIDTH = `COUNT_BITS,
  parameter int ACQ_PERIOD_CYCLES = `ACQ_PERIOD_MS * (`CLK_HZ / 1000),
  parameter int HEALTH_CYCLES = `HEALTH_PULSE_US * (`CLK_HZ / 1000000),
  parameter int WINDOW_BURSTS = `SLOSH_WINDOW_S * 1000 / `ACQ_PERIOD_MS
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic csThresholdReached,
  output logic dumpSwitch,
  output logic chargeSwitch,
  output logic transferSwitch,
  input wire logic polarityActiveHigh,
  input wire logic sloshFilterSelect,
  output logic lowLevelDetectOutput,
  output logic highLevelDetectOutput
);
  import level_pkg::*;
  localparam int SWITCH_CYCLES =
    (`SWITCH_NS * (`CLK_HZ / 1000000) + 999) / 1000;
  localparam int PW = $clog2(ACQ_PERIOD_CYCLES);
  localparam int TW = $clog2(SWITCH_CYCLES * `DUMP_PHASES + 1);
  localparam int HW = $clog2(HEALTH_CYCLES + 1);
  localparam logic [COUNT_WIDTH-1:0] LOW_LEVEL_THRESHOLD =
    COUNT_WIDTH'(`LOW_LEVEL_THRESHOLD);
  localparam logic [COUNT_WIDTH-1:0] HIGH_LEVEL_THRESHOLD =
    COUNT_WIDTH'(`HIGH_LEVEL_THRESHOLD);
  localparam logic [COUNT_WIDTH-1:0] COUNT_MAX = '1;
  localparam logic [TW-1:0] PHASE_LAST = TW'(SWITCH_CYCLES - 1);
  localparam logic [TW-1:0] DUMP_LAST =
    TW'(SWITCH_CYCLES * `DUMP_PHASES - 1);
  localparam logic [PW-1:0] PERIOD_LAST = PW'(ACQ_PERIOD_CYCLES - 1);
  localparam logic [HW-1:0] HEALTH_LEN = HW'(HEALTH_CYCLES);

  generate
    if (COUNT_WIDTH < 9)
    begin : g_bad_width
      $error("count width cannot hold the thresholds");
    end
    if (HEALTH_CYCLES < 1 || HEALTH_CYCLES >= ACQ_PERIOD_CYCLES)
    begin : g_bad_health
      $error("health pulse must fit inside one acquisition period");
    end
    if (ACQ_PERIOD_CYCLES < 64)
    begin : g_bad_period
      $error("acquisition period too short for a burst");
    end
  endgenerate

  // two-flop synchronisers for the comparator and option pins
  logic [2:0] pinMeta;
  logic [2:0] pinSync;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pinMeta <= '0;
      pinSync <= '0;
    end
    else
    begin
      pinMeta <= {sloshFilterSelect, polarityActiveHigh, csThresholdReached};
      pinSync <= pinMeta;
    end
  end
  logic csFull;
  logic activeHigh;
  logic filterOn;
  assign csFull = pinSync[0];
  assign activeHigh = pinSync[1];
  assign filterOn = pinSync[2];

  // register file
  logic [31:0] control;
  logic acqEnable;
  assign acqEnable = control[`CTRL_ACQ_EN];
  logic apbWrite;
  logic mapped;
  assign apbWrite = psel & penable & pwrite;
  always_comb
  begin
    case (paddr)
      `REG_CONTROL: mapped = 1'b1;
      `REG_COUNT: mapped = 1'b1;
      `REG_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  // zero wait states: read data is latched in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      control <= `CTRL_RESET;
    else if (apbWrite && paddr == `REG_CONTROL && pstrb[0])
      control[7:0] <= pwdata[7:0];
  end

  // acquisition period timer runs free, keeping bursts evenly spaced
  logic [PW-1:0] periodCount;
  logic periodTick;
  assign periodTick = (periodCount == PERIOD_LAST);
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      periodCount <= '0;
    else if (periodTick)
      periodCount <= '0;
    else
      periodCount <= periodCount + PW'(1);
  end

  acq_state_type state;
  acq_state_type next_state;
  logic [TW-1:0] phaseCount;
  logic [COUNT_WIDTH-1:0] burstCount;
  logic [COUNT_WIDTH-1:0] lastCount;
  logic saturated;
  logic phaseDone;
  logic burstEnd;
  assign phaseDone = (state == ST_DUMP) ? (phaseCount == DUMP_LAST)
                                        : (phaseCount == PHASE_LAST);
  assign burstEnd = csFull || burstCount == COUNT_MAX;

  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (periodTick && acqEnable)
          next_state = ST_DUMP;
      ST_DUMP:
        if (phaseDone)
          next_state = ST_CHARGE;
      ST_CHARGE:
        if (phaseDone)
          next_state = ST_TRANSFER;
      ST_TRANSFER:
        if (phaseDone)
          next_state = burstEnd ? ST_EVAL : ST_CHARGE;
      ST_EVAL:
        next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      phaseCount <= '0;
    else if (state != next_state || state == ST_IDLE)
      phaseCount <= '0;
    else
      phaseCount <= phaseCount + TW'(1);
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      burstCount <= '0;
    else if (state == ST_DUMP)
      burstCount <= '0;
    else if (state == ST_TRANSFER && phaseDone && !burstEnd)
      burstCount <= burstCount + COUNT_WIDTH'(1);
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      lastCount <= COUNT_MAX;
      saturated <= 1'b0;
    end
    else if (state == ST_EVAL)
    begin
      lastCount <= burstCount;
      saturated <= (burstCount == COUNT_MAX);
    end
  end

  // each switch compares the whole five-bit state vector, so it is a decode of several flops, not one;
  // only one switch closes at a time
  assign dumpSwitch = (state == ST_DUMP);
  assign chargeSwitch = (state == ST_CHARGE);
  assign transferSwitch = (state == ST_TRANSFER);

  // plain compare, no timeout or drift tracking
  detect_type rawDetect;
  assign rawDetect[CH_LOW] = (burstCount < LOW_LEVEL_THRESHOLD);
  assign rawDetect[CH_HIGH] = (burstCount < HIGH_LEVEL_THRESHOLD);
  logic [1:0] rawHeld;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rawHeld <= '0;
    else if (state == ST_EVAL)
      rawHeld <= rawDetect;
  end

  slosh_if sl();
  assign sl.sampleStrobe = (state == ST_EVAL);
  assign sl.rawDetect = rawDetect;
  assign sl.filterEnable = filterOn;
  slosh_filter #(
    .DEPTH(WINDOW_BURSTS)
  ) u_filter (
    .clk(clk),
    .sys_rst(sys_rst),
    .link(sl.filter)
  );

  logic [HW-1:0] healthCount;
  logic healthPulse;
  assign healthPulse = (healthCount != '0);
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      healthCount <= '0;
    else if (state == ST_EVAL)
      healthCount <= HEALTH_LEN;
    else if (healthPulse)
      healthCount <= healthCount - HW'(1);
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      lowLevelDetectOutput <= 1'b0;
      highLevelDetectOutput <= 1'b0;
    end
    else
    begin
      lowLevelDetectOutput <=
        (sl.filtered[CH_LOW] & ~healthPulse) ^ ~activeHigh;
      highLevelDetectOutput <=
        (sl.filtered[CH_HIGH] & ~healthPulse) ^ ~activeHigh;
    end
  end

  logic [31:0] status;
  always_comb
  begin
    status = '0;
    status[`ST_RAW_LOW] = rawHeld[CH_LOW];
    status[`ST_RAW_HIGH] = rawHeld[CH_HIGH];
    status[`ST_OUT_LOW] = sl.filtered[CH_LOW];
    status[`ST_OUT_HIGH] = sl.filtered[CH_HIGH];
    status[`ST_OPT_ACTIVE_HIGH] = activeHigh;
    status[`ST_OPT_FILTER] = filterOn;
    status[`ST_BUSY] = (state != ST_IDLE);
    status[`ST_SATURATED] = saturated;
  end

  // read data captured in setup so it stands through the access phase
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      prdata <= '0;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        `REG_CONTROL: prdata <= control;
        `REG_COUNT: prdata <= 32'(lastCount);
        `REG_STATUS: prdata <= status;
        default: prdata <= '0;
      endcase
    end
  end
endmodule // level_threshold_output_logic

/* level_threshold_output_logic_checker.sv */
// port assertions for the level sensor back end
// assumes one clock and the synchronous reset of the design
`timescale 1ns/1ns
`include "level_sense_map.svh"
module level_threshold_output_logic_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic csThresholdReached,
  input wire logic dumpSwitch,
  input wire logic chargeSwitch,
  input wire logic transferSwitch,
  input wire logic polarityActiveHigh,
  input wire logic sloshFilterSelect,
  input wire logic lowLevelDetectOutput,
  input wire logic highLevelDetectOutput
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  logic rdAcc;
  assign rdAcc = psel && penable && !pwrite;
  a_switch_onehot: assert property ($onehot0({dumpSwitch, chargeSwitch, transferSwitch}))
    else $error("two switches closed at once");
  a_dump_length: assert property ($rose(dumpSwitch) |-> ##16 chargeSwitch)
    else $error("dump phase length wrong");
  a_charge_length: assert property ($rose(chargeSwitch) |-> chargeSwitch[*4] ##1 transferSwitch)
    else $error("charge phase length wrong");
  a_transfer_length: assert property ($rose(transferSwitch) |-> transferSwitch[*4] ##1 !transferSwitch)
    else $error("transfer phase length wrong");
  a_burst_continues: assert property (($fell(transferSwitch) && !$past(csThresholdReached, 1)
    && !$past(csThresholdReached, 3) && !$past(csThresholdReached, 5)) |-> chargeSwitch)
    else $error("burst ended without comparator");
  a_health_pulse: assert property (($fell(transferSwitch) && !chargeSwitch
    && $past(polarityActiveHigh, 4) == polarityActiveHigh) |-> ##3
    (lowLevelDetectOutput == !polarityActiveHigh && highLevelDetectOutput == !polarityActiveHigh))
    else $error("health pulse missing");
  a_count_width: assert property (rdAcc && paddr == `REG_COUNT |-> prdata[31:14] == 18'h0)
    else $error("count wider than 14 bits");
  a_tier_order: assert property (rdAcc && paddr == `REG_STATUS |-> !prdata[1] || prdata[0])
    else $error("high tier without low tier");
  a_option_pins: assert property ((rdAcc && paddr == `REG_STATUS
    && $past(polarityActiveHigh, 6) == polarityActiveHigh
    && $past(sloshFilterSelect, 6) == sloshFilterSelect)
    |-> prdata[5:4] == {sloshFilterSelect, polarityActiveHigh})
    else $error("option pins not reported");
endmodule // level_threshold_output_logic_checker
bind level_threshold_output_logic level_threshold_output_logic_checker chk (.clk(clk),
  .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .csThresholdReached(csThresholdReached), .dumpSwitch(dumpSwitch),
  .chargeSwitch(chargeSwitch), .transferSwitch(transferSwitch),
  .polarityActiveHigh(polarityActiveHigh), .sloshFilterSelect(sloshFilterSelect),
  .lowLevelDetectOutput(lowLevelDetectOutput), .highLevelDetectOutput(highLevelDetectOutput));

/* probe_model.sv */
// probe and reservoir capacitor: comparator trips after a set number of transfers
// assumes the switch outputs of the back end and its clock
`timescale 1ns/1ns
module probe_model (
  input wire logic clk,
  input wire logic dumpSwitch,
  input wire logic transferSwitch,
  input wire logic [13:0] targetCount,
  output logic csThresholdReached
);
  int transfers = 0;
  logic prevTransfer = 1'b0;
  always @(posedge clk)
  begin
    prevTransfer <= transferSwitch;
    if (dumpSwitch)
      transfers <= 0;
    else if (prevTransfer && !transferSwitch)
      transfers <= transfers + 1;
  end
  assign csThresholdReached = !dumpSwitch && transfers >= int'(targetCount);
endmodule // probe_model

/* level_threshold_output_logic_tb.sv */
// self-checking bench for the level sensor back end over APB
// assumes the probe model and the bound checker; short period and window
`timescale 1ns/1ns
`include "level_sense_map.svh"
module level_threshold_output_logic_tb;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, polHigh = 1, filtOn = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'h1;
  logic [13:0] target = 14'h0064;
  logic pready, pslverr, err, cmpHigh, dumpSw, chargeSw, transferSw, lowOut, highOut, seen;
  int nFail = 0, nChecks = 0;
  int tlist[3] = '{100, 200, 280};
  always #50 clk = ~clk;
  level_threshold_output_logic #(.ACQ_PERIOD_CYCLES(3000), .HEALTH_CYCLES(4),
    .WINDOW_BURSTS(5)) dut (.clk(clk), .sys_rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .csThresholdReached(cmpHigh), .dumpSwitch(dumpSw),
    .chargeSwitch(chargeSw), .transferSwitch(transferSw), .polarityActiveHigh(polHigh),
    .sloshFilterSelect(filtOn), .lowLevelDetectOutput(lowOut), .highLevelDetectOutput(highOut));
  probe_model probe (.clk(clk), .dumpSwitch(dumpSw), .transferSwitch(transferSw),
    .targetCount(target), .csThresholdReached(cmpHigh));
  task complete_run;
    $display("checks %0d mismatches %0d", nChecks, nFail);
    if (nFail == 0 && nChecks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task check(input string what, input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp)
    begin
      nFail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // sample at negedges; checks the inactive pulse three cycles after the burst ends
  task wait_burst;
    do @(negedge clk); while (dumpSw !== 1'b1);
    do @(negedge clk); while (dumpSw || chargeSw || transferSw);
    repeat (3) @(negedge clk);
    check("health low", lowOut, !polHigh);
    check("health high", highOut, !polHigh);
    repeat (10) @(negedge clk);
  endtask
  task check_levels(input int t);
    apb(0, `REG_COUNT, 0);
    check("count", 32'(rd >= t - 1 && rd <= t + 1), 1);
    apb(0, `REG_STATUS, 0);
    check("raw detect", rd[1:0], {t < 150, t < 250});
    check("option pins", rd[5:4], {filtOn, polHigh});
    // outputs are flops: look at them away from the edge that updates them
    @(negedge clk);
    check("outputs", {highOut, lowOut} ^ {2{!polHigh}}, {t < 150, t < 250});
    check("single point", lowOut ^ !polHigh, t < 250);
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 0;
    apb(0, `REG_CONTROL, 0);
    check("control reset", rd, 32'h1);
    apb(0, `REG_COUNT, 0);
    check("count reset", rd, 32'h3fff);
    apb(0, 12'h00c, 0);
    check("unmapped error", err, 1);
    check("unmapped data", rd, 0);
    for (int i = 0; i < 3; i++)
    begin
      target <= 14'(tlist[i]);
      wait_burst();
      check_levels(tlist[i]);
    end
    polHigh <= 0;
    repeat (5) @(negedge clk);
    check_levels(280);
    target <= 14'h0064;
    wait_burst();
    check_levels(100);
    polHigh <= 1;
    filtOn <= 1;
    target <= 14'h0118;
    repeat (5) wait_burst();
    target <= 14'h0064;
    repeat (2) wait_burst();
    check("filter holds", lowOut, 0);
    wait_burst();
    check("filter sets", {highOut, lowOut}, 2'b11);
    @(posedge clk);
    filtOn <= 0;
    apb(1, `REG_CONTROL, 0);
    apb(0, `REG_CONTROL, 0);
    check("control write", rd, 0);
    seen = 0;
    repeat (6500) @(negedge clk) seen |= dumpSw;
    check("no burst", seen, 0);
    @(posedge clk);
    pstrb <= 4'h0;
    apb(1, `REG_CONTROL, 1);
    apb(0, `REG_CONTROL, 0);
    check("strobe off", rd, 0);
    pstrb <= 4'h1;
    apb(1, `REG_CONTROL, 1);
    wait_burst();
    check_levels(100);
    complete_run();
  end
  initial
  begin
    repeat (90000) @(posedge clk);
    nFail++;
    complete_run();
  end
endmodule // level_threshold_output_logic_tb
